// >>> rtl/vjd_pkg.sv
/*
 Constants, register map and timing counts of the vector jump detector.
 Assumes a 100 MHz system clock. Angles come in 0.01 degree steps and
 magnitudes in 0.01 percent of nominal voltage.
*/
package vjd_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_KHZ      = 100000;
   localparam int TRIP_HOLD_MS      = 20;
   localparam int STAMP_RES_MS      = 1;
   localparam int TRIP_HOLD_CYC     = TRIP_HOLD_MS * CLK_FREQ_KHZ;
   localparam int MS_CYC            = STAMP_RES_MS * CLK_FREQ_KHZ;
   localparam int SAMPLES_PER_CYCLE = 64;

   // ----------------------------------------------------------------
   // Channels and setting groups
   // ----------------------------------------------------------------
   localparam int NCH   = 7;
   localparam int NGRP  = 8;
   localparam int ANG_W = 16;
   localparam int CNT_W = 16;
   localparam logic signed [17:0] ANG_FULL = 18'sh08CA0;
   localparam logic signed [17:0] ANG_HALF = 18'sh04650;

   // ----------------------------------------------------------------
   // Register byte offsets and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STAT     = 8'h04;
   localparam logic [7:0] REG_CNT_ALM  = 8'h08;
   localparam logic [7:0] REG_CNT_TRP  = 8'h0C;
   localparam logic [7:0] REG_CNT_BLK  = 8'h10;
   localparam logic [7:0] REG_STAMP    = 8'h14;
   localparam logic [7:0] REG_SMPIDX   = 8'h18;
   localparam int         GRP_SEL_BIT  = 7;
   localparam int         PAR_TRIP     = 0;
   localparam int         PAR_ALARM    = 1;
   localparam int         PAR_UV       = 2;
   localparam int         CTRL_MODE    = 0;
   localparam int         CTRL_MON_LSB = 4;
   localparam int         CTRL_GRP_LSB = 8;
   localparam int         CTRL_CLR     = 16;
   localparam int         OUT_ALARM    = 0;
   localparam int         OUT_TRIP     = 1;
   localparam int         OUT_BLK      = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic       MODE_RST     = 1'h0;
   localparam logic [3:0] MON_RST      = 4'h1;
   localparam logic [2:0] GRP_RST      = 3'h0;
   localparam logic [15:0] THR_RST     = 16'h01F4;
   localparam logic [15:0] UV_RST      = 16'h251C;
endpackage

// >>> rtl/vjd_top.sv
/*
 Vector jump islanding detector with a classic Wishbone register slave.
 Assumes samples of all seven voltage channels arrive together, one strobe
 per sample, from logic on MCLK_I; the external block is an async pin.
 Events leave as a one-cycle word for the common event buffer.
*/
`timescale 1ns/100ps
module vjd_top
   import vjd_pkg::*;
#(
   parameter int TRIP_HOLD_CYC_P = TRIP_HOLD_CYC,
   parameter int MS_CYC_P        = MS_CYC
)
(
   input  wire logic                 MCLK_I,
   input  wire logic                 RESET_N_I,
   input  wire logic [7:0]           WB_ADR_I,
   input  wire logic [31:0]          WB_DAT_I,
   input  wire logic [3:0]           WB_SEL_I,
   input  wire logic                 WB_WE_I,
   input  wire logic                 WB_CYC_I,
   input  wire logic                 WB_STB_I,
   output logic      [31:0]          WB_DAT_O,
   output logic                      WB_ACK_O,
   input  wire logic                 SMP_VALID_I,
   input  wire logic [NCH*ANG_W-1:0] SMP_ANGLE_I,
   input  wire logic [NCH*ANG_W-1:0] SMP_MAG_I,
   input  wire logic                 EXT_BLOCK_I,
   output logic                      ALARM_O,
   output logic                      TRIP_O,
   output logic                      BLOCKED_O,
   output logic                      EVT_VALID_O,
   output logic      [2:0]           EVT_ON_O,
   output logic      [2:0]           EVT_OFF_O,
   output logic      [31:0]          EVT_STAMP_O
);

   localparam int TW = $clog2(TRIP_HOLD_CYC_P + 1);
   localparam int MW = $clog2(MS_CYC_P + 1);
   localparam logic [TW-1:0] HOLD_LD = TW'(TRIP_HOLD_CYC_P);
   localparam logic [MW-1:0] MS_LAST = MW'(MS_CYC_P - 1);

   if (TRIP_HOLD_CYC_P < 2 || MS_CYC_P < 1)
   begin : g_chk
      $error("vjd_top: hold and millisecond counts out of range");
   end

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic [15:0] ang_step(input logic [15:0] a, input logic [15:0] b);
      logic signed [17:0] d;
      d = $signed({2'h0, a}) - $signed({2'h0, b});
      if (d > ANG_HALF)
         d = d - ANG_FULL;
      else if (d < -ANG_HALF)
         d = d + ANG_FULL;
      if (d < 0)
         d = -d;
      return d[15:0];
   endfunction

   // Returns {all_required, channel mask}; an empty mask means invalid choice
   function automatic logic [7:0] mon_decode(input logic [3:0] m);
      logic [7:0] r;
      r = 8'h00;
      unique case (m)
         4'h0:    r = 8'h87;
         4'h1:    r = 8'h07;
         4'h2:    r = 8'h01;
         4'h3:    r = 8'h02;
         4'h4:    r = 8'h04;
         4'h5:    r = 8'hB8;
         4'h6:    r = 8'h38;
         4'h7:    r = 8'h08;
         4'h8:    r = 8'h10;
         4'h9:    r = 8'h20;
         4'hA:    r = 8'h40;
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            r[i*8 +: 8] = dat[i*8 +: 8];
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic              mode_ff;
   logic [3:0]        mon_ff;
   logic [2:0]        grp_ff;
   logic [15:0]       par_ff [NGRP][3];
   logic              ack_ff;
   logic [31:0]       rdat_ff;
   logic              ext_s1_ff;
   logic              ext_s2_ff;
   logic [MW-1:0]     ms_cnt_ff;
   logic [31:0]       stamp_ff;
   logic [5:0]        smp_idx_ff;
   logic              s1_vld_ff;
   logic [15:0]       s1_ang_ff [NCH];
   logic [15:0]       s1_mag_ff [NCH];
   logic [15:0]       prev_ang_ff [NCH];
   logic              prev_ok_ff;
   logic              s2_vld_ff;
   logic [15:0]       step_ff [NCH];
   logic [NCH-1:0]    low_ff;
   logic              s3_vld_ff;
   logic              trip_hit_ff;
   logic              alarm_hit_ff;
   logic              uv_blk_ff;
   logic [TW-1:0]     tmr_ff [2];
   logic [2:0]        out_ff;
   logic [2:0]        out_prev_ff;
   logic [CNT_W-1:0]  cnt_ff [3];
   logic              evt_vld_ff;
   logic [2:0]        evt_on_ff;
   logic [2:0]        evt_off_ff;
   logic [31:0]       evt_stamp_ff;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire         acc      = WB_CYC_I & WB_STB_I & ~ack_ff;
   wire         wr       = acc & WB_WE_I;
   wire         grp_hit  = WB_ADR_I[GRP_SEL_BIT];
   wire  [2:0]  adr_grp  = WB_ADR_I[6:4];
   wire  [1:0]  adr_word = WB_ADR_I[3:2];
   wire         par_hit  = grp_hit & (adr_word != 2'h3);
   wire         ctrl_wr  = wr & (WB_ADR_I == REG_CTRL);
   wire  [31:0] ctrl_rd  = {15'h0000, 1'h0, 5'h00, grp_ff, mon_ff, 3'h0, mode_ff};
   wire  [31:0] ctrl_new = wb_merge(ctrl_rd, WB_DAT_I, WB_SEL_I);
   wire         cnt_clr  = ctrl_wr & ctrl_new[CTRL_CLR];
   wire  [31:0] par_rd   = par_hit ? {16'h0000, par_ff[adr_grp][adr_word]} : 32'h0000_0000;
   wire  [31:0] par_new  = wb_merge(par_rd, WB_DAT_I, WB_SEL_I);
   wire  [7:0]  mon_dec  = mon_decode(mon_ff);
   wire         mon_all  = mon_dec[7];
   wire [NCH-1:0] mon_msk = mon_dec[NCH-1:0];
   wire         sel_bad  = (mon_msk == '0);
   wire  [31:0] stat_rd  = {26'h0, uv_blk_ff, ext_s2_ff, sel_bad, out_ff};
   logic [31:0] rd_mux;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (grp_hit)
         rd_mux = par_rd;
      else
         unique case (WB_ADR_I)
            REG_CTRL:    rd_mux = ctrl_rd;
            REG_STAT:    rd_mux = stat_rd;
            REG_CNT_ALM: rd_mux = {16'h0000, cnt_ff[OUT_ALARM]};
            REG_CNT_TRP: rd_mux = {16'h0000, cnt_ff[OUT_TRIP]};
            REG_CNT_BLK: rd_mux = {16'h0000, cnt_ff[OUT_BLK]};
            REG_STAMP:   rd_mux = stamp_ff;
            REG_SMPIDX:  rd_mux = {26'h0, smp_idx_ff};
            default:     rd_mux = 32'h0000_0000;
         endcase
   end

   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         ack_ff  <= 1'h0;
         rdat_ff <= 32'h0000_0000;
         mode_ff <= MODE_RST;
         mon_ff  <= MON_RST;
         grp_ff  <= GRP_RST;
      end
      else
      begin
         ack_ff <= acc;
         if (acc)
            rdat_ff <= rd_mux;
         if (ctrl_wr)
         begin
            mode_ff <= ctrl_new[CTRL_MODE];
            mon_ff  <= ctrl_new[CTRL_MON_LSB +: 4];
            grp_ff  <= ctrl_new[CTRL_GRP_LSB +: 3];
         end
      end
   end

   // Eight parameter sets, each trip threshold, alarm threshold, undervoltage limit
   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         for (int g = 0; g < NGRP; g++)
         begin
            par_ff[g][PAR_TRIP]  <= THR_RST;
            par_ff[g][PAR_ALARM] <= THR_RST;
            par_ff[g][PAR_UV]    <= UV_RST;
         end
      end
      else if (wr && par_hit)
         par_ff[adr_grp][adr_word] <= par_new[15:0];
   end

   // ----------------------------------------------------------------
   // Pin synchroniser and millisecond time base
   // ----------------------------------------------------------------
   wire ms_tick = (ms_cnt_ff == MS_LAST);

   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         ext_s1_ff <= 1'h0;
         ext_s2_ff <= 1'h0;
         ms_cnt_ff <= '0;
         stamp_ff  <= 32'h0000_0000;
      end
      else
      begin
         ext_s1_ff <= EXT_BLOCK_I;
         ext_s2_ff <= ext_s1_ff;
         ms_cnt_ff <= ms_tick ? '0 : ms_cnt_ff + MW'(1);
         if (ms_tick)
            stamp_ff <= stamp_ff + 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // Measurement pipeline
   // ----------------------------------------------------------------
   wire [15:0]    thr_trip  = par_ff[grp_ff][PAR_TRIP];
   wire [15:0]    thr_alarm = par_ff[grp_ff][PAR_ALARM];
   wire [15:0]    uv_lim    = par_ff[grp_ff][PAR_UV];
   logic [NCH-1:0] trip_raw;
   logic [NCH-1:0] alarm_raw;

   always_comb
   begin
      for (int i = 0; i < NCH; i++)
      begin
         trip_raw[i]  = (step_ff[i] >= thr_trip);
         alarm_raw[i] = (step_ff[i] >= thr_alarm);
      end
   end

   wire trip_sel  = mon_all ? (&(trip_raw | ~mon_msk) & ~sel_bad) : |(trip_raw & mon_msk);
   wire alarm_sel = mon_all ? (&(alarm_raw | ~mon_msk) & ~sel_bad) : |(alarm_raw & mon_msk);

   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         s1_vld_ff    <= 1'h0;
         s2_vld_ff    <= 1'h0;
         s3_vld_ff    <= 1'h0;
         prev_ok_ff   <= 1'h0;
         low_ff       <= '0;
         trip_hit_ff  <= 1'h0;
         alarm_hit_ff <= 1'h0;
         uv_blk_ff    <= 1'h0;
         smp_idx_ff   <= 6'h00;
         for (int i = 0; i < NCH; i++)
         begin
            s1_ang_ff[i]   <= 16'h0000;
            s1_mag_ff[i]   <= 16'h0000;
            prev_ang_ff[i] <= 16'h0000;
            step_ff[i]     <= 16'h0000;
         end
      end
      else
      begin
         // Input selection: capture all channels of one sample
         s1_vld_ff <= SMP_VALID_I;
         if (SMP_VALID_I)
         begin
            smp_idx_ff <= 6'(smp_idx_ff + 6'h01);
            for (int i = 0; i < NCH; i++)
            begin
               s1_ang_ff[i] <= SMP_ANGLE_I[i*ANG_W +: ANG_W];
               s1_mag_ff[i] <= SMP_MAG_I[i*ANG_W +: ANG_W];
            end
         end
         // Input processing: angle step against the previous sample
         s2_vld_ff <= s1_vld_ff;
         if (s1_vld_ff)
         begin
            prev_ok_ff <= 1'h1;
            for (int i = 0; i < NCH; i++)
            begin
               prev_ang_ff[i] <= s1_ang_ff[i];
               step_ff[i]     <= prev_ok_ff ? ang_step(s1_ang_ff[i], prev_ang_ff[i]) : 16'h0000;
               low_ff[i]      <= (s1_mag_ff[i] < uv_lim);
            end
         end
         // Threshold comparison with the live setting group
         s3_vld_ff <= s2_vld_ff;
         if (s2_vld_ff)
         begin
            trip_hit_ff  <= trip_sel;
            alarm_hit_ff <= alarm_sel;
            uv_blk_ff    <= |(low_ff & mon_msk);
         end
      end
   end

   // ----------------------------------------------------------------
   // Block check, hold timers and outputs
   // ----------------------------------------------------------------
   wire        blocked_now = uv_blk_ff | ext_s2_ff;
   wire        trip_start  = s3_vld_ff & trip_hit_ff & ~blocked_now;
   wire        alarm_start = mode_ff & s3_vld_ff & (alarm_hit_ff | trip_hit_ff) & ~blocked_now;
   logic [TW-1:0] nxt_tmr [2];
   logic [2:0]    nxt_out;

   always_comb
   begin
      for (int k = 0; k < 2; k++)
      begin
         if (blocked_now)
            nxt_tmr[k] = '0;
         else if (k == OUT_ALARM ? alarm_start : trip_start)
            nxt_tmr[k] = HOLD_LD;
         else if (tmr_ff[k] != '0)
            nxt_tmr[k] = tmr_ff[k] - TW'(1);
         else
            nxt_tmr[k] = '0;
      end
      if (!mode_ff)
         nxt_tmr[OUT_ALARM] = '0;
      nxt_out[OUT_ALARM] = (nxt_tmr[OUT_ALARM] != '0);
      nxt_out[OUT_TRIP]  = (nxt_tmr[OUT_TRIP] != '0);
      nxt_out[OUT_BLK]   = blocked_now;
   end

   wire [2:0] ev_on  = out_ff & ~out_prev_ff;
   wire [2:0] ev_off = ~out_ff & out_prev_ff;

   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         tmr_ff[0]    <= '0;
         tmr_ff[1]    <= '0;
         out_ff       <= 3'h0;
         out_prev_ff  <= 3'h0;
         evt_vld_ff   <= 1'h0;
         evt_on_ff    <= 3'h0;
         evt_off_ff   <= 3'h0;
         evt_stamp_ff <= 32'h0000_0000;
         for (int k = 0; k < 3; k++)
            cnt_ff[k] <= '0;
      end
      else
      begin
         tmr_ff[0]   <= nxt_tmr[0];
         tmr_ff[1]   <= nxt_tmr[1];
         out_ff      <= nxt_out;
         out_prev_ff <= out_ff;
         evt_vld_ff  <= |(ev_on | ev_off);
         evt_on_ff   <= ev_on;
         evt_off_ff  <= ev_off;
         if (|(ev_on | ev_off))
            evt_stamp_ff <= stamp_ff;
         for (int k = 0; k < 3; k++)
         begin
            if (cnt_clr)
               cnt_ff[k] <= CNT_W'(ev_on[k]);
            else if (ev_on[k] && cnt_ff[k] != '1)
               cnt_ff[k] <= cnt_ff[k] + CNT_W'(1);
         end
      end
   end

   assign WB_DAT_O    = rdat_ff;
   assign WB_ACK_O    = ack_ff;
   assign ALARM_O     = out_ff[OUT_ALARM];
   assign TRIP_O      = out_ff[OUT_TRIP];
   assign BLOCKED_O   = out_ff[OUT_BLK];
   assign EVT_VALID_O = evt_vld_ff;
   assign EVT_ON_O    = evt_on_ff;
   assign EVT_OFF_O   = evt_off_ff;
   assign EVT_STAMP_O = evt_stamp_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RESET_N_I);

   AST_BLOCK_SUPPRESS: assert property (blocked_now |=> !TRIP_O && !ALARM_O && BLOCKED_O)
      else $error("block did not suppress outputs");
   AST_EXT_BLOCK: assert property ($rose(ext_s2_ff) |=> BLOCKED_O)
      else $error("external block not shown");
   AST_TRIP_START: assert property (trip_start |=> TRIP_O && tmr_ff[OUT_TRIP] == HOLD_LD)
      else $error("trip not started on pick-up");
   AST_NO_START_BLOCKED: assert property (!TRIP_O && blocked_now |=> !TRIP_O)
      else $error("trip started while blocked");
   AST_TRIP_RELEASE: assert property (TRIP_O && tmr_ff[OUT_TRIP] == TW'(1) && !trip_start |=> !TRIP_O)
      else $error("trip not released after hold");
   AST_TRIP_HOLDS: assert property (TRIP_O && tmr_ff[OUT_TRIP] > TW'(1) && !blocked_now |=> TRIP_O)
      else $error("trip dropped early");
   AST_ALARM_MODE: assert property (!mode_ff |=> !ALARM_O)
      else $error("alarm in trip-only mode");
   AST_EVT_RISE: assert property ($rose(TRIP_O) |=> EVT_VALID_O && EVT_ON_O[OUT_TRIP])
      else $error("missing trip on event");
   AST_EVT_FALL: assert property ($fell(BLOCKED_O) |=> EVT_VALID_O && EVT_OFF_O[OUT_BLK])
      else $error("missing blocked off event");
   AST_SAME_STAMP: assert property ($rose(TRIP_O) && $rose(ALARM_O) |=> EVT_ON_O == 3'h3)
      else $error("alarm and trip events split");
   AST_STAMP_MS: assert property ($changed(stamp_ff) |-> $past(ms_tick))
      else $error("stamp moved off millisecond tick");
   AST_CNT_CLR: assert property (cnt_clr && !ev_on[OUT_TRIP] |=> cnt_ff[OUT_TRIP] == '0)
      else $error("trip count not cleared");
   AST_WB_ACK: assert property (acc |=> WB_ACK_O ##1 !WB_ACK_O)
      else $error("bus ack not one cycle");

   COV_TRIP: cover property ($rose(TRIP_O) ##[1:8] EVT_VALID_O);
   COV_TRIP_ALARM: cover property ($rose(TRIP_O) && $rose(ALARM_O));
   COV_BLOCK_DURING_TRIP: cover property (TRIP_O ##1 BLOCKED_O && !TRIP_O);
endmodule

// >>> dv/vjd_top_tb_top.sv
/*
 Self-checking bench for vjd_top: registers over classic Wishbone,
 samples and the block pin driven straight from the bench.
 Assumes short hold (50) and millisecond (10) counts.
*/
`timescale 1ns/100ps
module vjd_top_tb_top;
   import vjd_pkg::*;
   localparam int HOLD = 50;
   logic                 clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, sv = 0, xb = 0;
   logic [7:0]           adr = '0;
   logic [31:0]          wdat = '0;
   logic [3:0]           sel = '0;
   logic [NCH*ANG_W-1:0] ang = '0, mag = '0;
   logic [31:0]          rdat, q, t0, st, est;
   logic                 ack, alm, trp, blk, ev;
   logic [2:0]           on, off, on_acc, off_acc;
   logic [15:0]          cur = '0, mv = 16'h2710;
   int                   n_mismatch = 0, n_checks = 0, tick = 0, n_smp = 0;

   vjd_top #(.TRIP_HOLD_CYC_P(HOLD), .MS_CYC_P(10)) dut (.MCLK_I(clk), .RESET_N_I(rst_n),
      .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .SMP_VALID_I(sv), .SMP_ANGLE_I(ang), .SMP_MAG_I(mag),
      .EXT_BLOCK_I(xb), .ALARM_O(alm), .TRIP_O(trp), .BLOCKED_O(blk), .EVT_VALID_O(ev),
      .EVT_ON_O(on), .EVT_OFF_O(off), .EVT_STAMP_O(st));

   always #5 clk = ~clk;

   // ----------------------------------------------------------------
   // Event capture and timeout
   // ----------------------------------------------------------------
   always @(posedge clk)
   begin
      tick++;
      if (ev === 1'b1)
      begin
         on_acc = on_acc | on;
         off_acc = off_acc | off;
         if (on !== 3'h0)
            est = st;
      end
      if (tick == 20000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
      @(posedge clk);
      while (ack !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 20) n_mismatch++;
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(a, 1'b0, 32'h0);
      check(q, exp);
   endtask

   task automatic smp(input logic [15:0] a);
      @(posedge clk);
      sv <= 1'b1; ang <= {NCH{a}}; mag <= {NCH{mv}};
      n_smp++;
      @(posedge clk);
      sv <= 1'b0;
   endtask

   // Angle step of d on every channel, then trip, alarm and events
   task automatic jump(input logic [15:0] d, input logic et, input logic ea);
      smp(cur);
      cur = cur + d;
      on_acc = '0;
      smp(cur);
      repeat (8) @(posedge clk);
      check(trp, et); // Trip on step
      check(alm, ea); // Alarm per mode
      check(on_acc, {1'b0, et, ea}); // On events of trip and alarm
      if (et)
      begin
         repeat (32) @(posedge clk);
         check(trp, 1'b1); // Still held
         off_acc = '0;
         repeat (28) @(posedge clk);
         check(trp, 1'b0); // Released
         check(off_acc, {1'b0, 1'b1, ea}); // Off events
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(REG_CTRL, 32'h10); // Trip only, any P-P
      rd(8'h80, 32'h1F4); // Trip level
      rd(8'h84, 32'h1F4); // Alarm level
      rd(8'hF8, 32'h251C); // Last group limit
      rd(8'h1C, 32'h0); // Unmapped place reads zero
      $display("test reset values done");
      jump(16'h0258, 1'b1, 1'b0); // Mode 0 trip
      jump(16'h0190, 1'b0, 1'b0); // Below level
      wb(REG_CTRL, 1'b1, 32'h11);
      jump(16'h0258, 1'b1, 1'b1); // Trip with alarm
      $display("test pick-up done");
      wb(8'h90, 1'b1, 32'h3E8);
      wb(8'h94, 1'b1, 32'h3E8);
      wb(REG_CTRL, 1'b1, 32'h111);
      jump(16'h0258, 1'b0, 1'b0); // Group one level
      jump(16'h04B0, 1'b1, 1'b1); // Group one trips
      $display("test setting groups done");
      @(posedge clk);
      xb <= 1'b1;
      repeat (6) @(posedge clk);
      check(blk, 1'b1); // External block
      rd(REG_STAT, 32'h14); // Status shows pin block
      jump(16'h04B0, 1'b0, 1'b0); // No start while blocked
      xb <= 1'b0;
      repeat (6) @(posedge clk);
      check(blk, 1'b0); // Block removed
      mv = 16'h2328;
      smp(cur);
      repeat (8) @(posedge clk);
      check(blk, 1'b1); // Undervoltage block
      rd(REG_STAT, 32'h24); // Status shows undervoltage block
      jump(16'h04B0, 1'b0, 1'b0); // Suppressed
      mv = 16'h2710;
      smp(cur);
      repeat (8) @(posedge clk);
      check(blk, 1'b0); // Voltage back
      $display("test blocking done");
      rd(REG_CNT_TRP, 32'h3); // Trip count
      rd(REG_CNT_ALM, 32'h2); // Alarm count
      rd(REG_CNT_BLK, 32'h2); // Blocked count
      wb(REG_CTRL, 1'b1, 32'h10111);
      rd(REG_CNT_TRP, 32'h0); // Cleared
      wb(REG_CTRL, 1'b1, 32'h1F1);
      rd(REG_STAT, 32'h8); // Invalid selection flagged
      jump(16'h04B0, 1'b0, 1'b0); // No pick-up on invalid choice
      wb(REG_CTRL, 1'b1, 32'h101);
      jump(16'h04B0, 1'b1, 1'b1); // All P-P voltages
      rd(REG_CNT_TRP, 32'h1); // Counts again after clear
      rd(REG_SMPIDX, n_smp % 64); // Sample index
      wb(REG_STAMP, 1'b0, 32'h0);
      t0 = q;
      repeat (100) @(posedge clk);
      wb(REG_STAMP, 1'b0, 32'h0);
      check((q - t0 >= 10) && (q - t0 <= 11), 1'b1); // Millisecond steps
      t0 = q;
      jump(16'h04B0, 1'b1, 1'b1); // Trip for event stamp
      check((est - t0) <= 2, 1'b1); // Event stamp in milliseconds
      $display("test counters and stamp done");
      give_verdict();
   end
endmodule
